/* logic/mux_switch_control_port.sv */
// What this block does
// - Config high gives dual 4-channel mux, low gives single 8-channel mux.
// - Serial mode reset clears latches and shift register, opens all switches.
// - Parallel mode reset clears latches and opens all switches.
// - Strobe pin is latch enable in parallel mode, chip select in serial.
// - Parallel, config low: top pin is address MSB; config high: ignored.
// - Serial data sampled on each rising shift clock edge while chip select is low.
// - Parallel mode: middle pin is address, lowest pin is address LSB.
// - Serial mode: lowest pin outputs end of 4-bit shift register.
// - Serial output stays driven whatever the chip select level.
// - Enable low turns every channel off; high follows latched selection.
// - Enable acts at once in serial mode, latched in parallel mode.
// - Interface select low is parallel; high is serial with output driven.
`include "mux_ctl_regs.svh"
module mux_switch_control_port
  import mux_ctl_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 arst_n,
  input  wire logic                 switch_reset_n,
  input  wire logic                 hold_strobe,
  input  wire logic                 sel_msb,
  input  wire logic                 sel_mid,
  input  wire logic                 sel_lsb_in,
  input  wire logic                 switch_enable,
  input  wire logic                 interface_select,
  input  wire logic                 dual_config,
  output logic                      sel_lsb_out,
  output logic                      sel_lsb_oe,
  output mux_ctl_pkg::switch_t      switch_on
);
  import mux_ctl_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  localparam int NSYNC = 8;
  localparam logic [NSYNC-1:0] SYNC_IDLE = `SYNC_RESET;
  logic [NSYNC-1:0] raw;
  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;
  assign raw = {switch_reset_n, hold_strobe, sel_msb, sel_mid, sel_lsb_in,
                switch_enable, interface_select, dual_config};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++)
    begin : g_sync
      always_ff @(posedge mclk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          sync1[gi] <= SYNC_IDLE[gi];
          sync2[gi] <= SYNC_IDLE[gi];
        end
        else
        begin
          sync1[gi] <= raw[gi];
          sync2[gi] <= sync1[gi];
        end
      end
    end
  endgenerate

  logic s_rst_n;
  logic s_strobe;
  logic s_msb;
  logic s_mid;
  logic s_lsb;
  logic s_en;
  logic s_serial;
  logic s_dual;
  assign {s_rst_n, s_strobe, s_msb, s_mid, s_lsb, s_en, s_serial, s_dual} = sync2;

  ////////////////////////////////////////////////////////////////////////
  // Edge detection on strobe and shift clock
  logic strobe_d;
  logic sclk_d;
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      strobe_d <= `STROBE_IDLE;
      sclk_d   <= 1'b0;
    end
    else
    begin
      strobe_d <= s_strobe;
      sclk_d   <= s_msb;
    end
  end

  logic sclk_rise;
  logic cs_rise;
  assign sclk_rise = s_msb & ~sclk_d;
  assign cs_rise   = s_strobe & ~strobe_d;

  ////////////////////////////////////////////////////////////////////////
  // Shift register
  logic [`SHIFT_BITS-1:0] shift;
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      shift <= `SHIFT_RESET;
    else if (!s_rst_n)
      shift <= `SHIFT_RESET;
    else if (s_serial && !s_strobe && sclk_rise)
      shift <= {shift[`SHIFT_BITS-2:0], s_mid};
  end

  ////////////////////////////////////////////////////////////////////////
  // Selection latch
  selection_s held;
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      held <= '0;
    else if (!s_rst_n)
      held <= '0;
    else if (s_serial)
    begin
      if (cs_rise)
        held <= selection_s'(shift);
    end
    else if (!s_strobe)
      held <= '{sel_msb: s_msb, sel_mid: s_mid, sel_lsb: s_lsb, enable: s_en};
  end

  ////////////////////////////////////////////////////////////////////////
  // Decode
  logic    eff_en;
  switch_t next_switch_on;
  always_comb
  begin
    eff_en = s_serial ? s_en : held.enable;
    next_switch_on = `SWITCH_RESET;
    if (eff_en && s_rst_n)
    begin
      if (s_dual)
      begin
        next_switch_on[{1'b0, held.sel_mid, held.sel_lsb}] = 1'b1;
        next_switch_on[{1'b1, held.sel_mid, held.sel_lsb}] = 1'b1;
      end
      else
        next_switch_on[{held.sel_msb, held.sel_mid, held.sel_lsb}] = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      switch_on <= `SWITCH_RESET;
    else
      switch_on <= next_switch_on;
  end

  ////////////////////////////////////////////////////////////////////////
  // Daisy-chain output
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sel_lsb_out <= `DOUT_RESET;
      sel_lsb_oe  <= 1'b0;
    end
    else
    begin
      sel_lsb_out <= shift[`SHIFT_BITS-1];
      sel_lsb_oe  <= s_serial;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  localparam int HALF = `SWITCH_COUNT / 2;

  a_enable_off: assert property (@(posedge mclk) disable iff (!arst_n)
    (s_serial && !s_en)
    |=> (switch_on == `SWITCH_RESET))
    else
      $error("switches on while enable low");

  a_reset_open: assert property (@(posedge mclk) disable iff (!arst_n)
    !s_rst_n
    |=> (switch_on == `SWITCH_RESET) && (held == '0))
    else
      $error("reset did not open switches");

  a_shift_clear: assert property (@(posedge mclk) disable iff (!arst_n)
    !s_rst_n
    |=> shift == `SHIFT_RESET)
    else
      $error("shift register not cleared");

  a_shift_in: assert property (@(posedge mclk) disable iff (!arst_n)
    (s_rst_n && s_serial && !s_strobe && sclk_rise)
    |=> shift[0] == $past(s_mid))
    else
      $error("serial bit not sampled");

  a_cs_load: assert property (@(posedge mclk) disable iff (!arst_n)
    (s_rst_n && s_serial && cs_rise)
    |=> held == selection_s'($past(shift)))
    else
      $error("shift not copied on chip select");

  a_oe_serial: assert property (@(posedge mclk) disable iff (!arst_n)
    ##1 (sel_lsb_oe == $past(s_serial)))
    else
      $error("output enable wrong");

  a_dout_tail: assert property (@(posedge mclk) disable iff (!arst_n)
    ##1 (sel_lsb_out == $past(shift[`SHIFT_BITS-1])))
    else
      $error("daisy output wrong");

  a_one_hot: assert property (@(posedge mclk) disable iff (!arst_n)
    (switch_on != `SWITCH_RESET)
    |-> ($countones(switch_on) == (s_dual ? 2 : 1)) || $changed(s_dual))
    else
      $error("wrong switch count");

  a_par_latch: assert property (@(posedge mclk) disable iff (!arst_n)
    (s_rst_n && !s_serial && s_strobe)
    |=> $stable(held) || !s_rst_n || s_serial)
    else
      $error("latch changed while held");

  a_rst_par: assert property (@(posedge mclk) disable iff (!arst_n)
    (!s_rst_n && !s_serial)
    |=> (held == '0) && (switch_on == `SWITCH_RESET))
    else
      $error("parallel reset did not open switches");

  a_single_pick: assert property (@(posedge mclk) disable iff (!arst_n)
    (s_rst_n && !s_serial && !s_dual && held.enable)
    |=> switch_on == (`SWITCH_ONE << $past({held.sel_msb, held.sel_mid, held.sel_lsb})))
    else
      $error("single mode picked wrong switch");

  a_dual_pair: assert property (@(posedge mclk) disable iff (!arst_n)
    (s_rst_n && s_dual && held.enable && !s_serial)
    |=> (switch_on[`SWITCH_COUNT-1 -: HALF] == switch_on[HALF-1:0]) && ($countones(switch_on[HALF-1:0]) == 1))
    else
      $error("dual mode halves differ");

  a_msb_ignored: assert property (@(posedge mclk) disable iff (!arst_n)
    (s_rst_n && s_dual && held.enable && !s_serial)
    |=> switch_on[$past({1'b0, held.sel_mid, held.sel_lsb})])
    else
      $error("top address pin not ignored");

  a_lsb_pick: assert property (@(posedge mclk) disable iff (!arst_n)
    (s_rst_n && !s_serial && held.enable)
    |=> (|(switch_on & `ODD_SWITCHES)) == $past(held.sel_lsb))
    else
      $error("lowest pin not address lsb");

  a_mid_pick: assert property (@(posedge mclk) disable iff (!arst_n)
    (s_rst_n && !s_serial && held.enable)
    |=> (|(switch_on & `MID_SWITCHES)) == $past(held.sel_mid))
    else
      $error("middle pin not address bit");

  a_par_track: assert property (@(posedge mclk) disable iff (!arst_n)
    (s_rst_n && !s_serial && !s_strobe)
    |=> held == $past({s_msb, s_mid, s_lsb, s_en}))
    else
      $error("transparent latch did not follow");

  a_par_en_off: assert property (@(posedge mclk) disable iff (!arst_n)
    (s_rst_n && !s_serial && !held.enable)
    |=> switch_on == `SWITCH_RESET)
    else
      $error("latched enable ignored");

  a_serial_hold: assert property (@(posedge mclk) disable iff (!arst_n)
    (s_rst_n && s_serial && !cs_rise)
    |=> $stable(held))
    else
      $error("selection changed without chip select");

  a_shift_still: assert property (@(posedge mclk) disable iff (!arst_n)
    (s_rst_n && (!s_serial || s_strobe || !sclk_rise))
    |=> $stable(shift))
    else
      $error("shift moved while idle");

  a_shift_move: assert property (@(posedge mclk) disable iff (!arst_n)
    (s_rst_n && s_serial && !s_strobe && sclk_rise)
    |=> shift[`SHIFT_BITS-1:1] == $past(shift[`SHIFT_BITS-2:0]))
    else
      $error("shift register did not advance");

  a_en_serial_on: assert property (@(posedge mclk) disable iff (!arst_n)
    (s_rst_n && s_serial && s_en)
    |=> switch_on != `SWITCH_RESET)
    else
      $error("enabled serial mux has no switch");

  a_dout_cs: assert property (@(posedge mclk) disable iff (!arst_n)
    (s_serial && s_strobe)
    |=> sel_lsb_oe)
    else
      $error("daisy output released by chip select");

  a_oe_parallel: assert property (@(posedge mclk) disable iff (!arst_n)
    !s_serial
    |=> !sel_lsb_oe)
    else
      $error("daisy output driven in parallel mode");

  c_serial_load: cover property (@(posedge mclk) disable iff (!arst_n)
    s_serial && cs_rise);
  c_par_dual: cover property (@(posedge mclk) disable iff (!arst_n)
    !s_serial && s_dual && switch_on != `SWITCH_RESET);
  c_par_single: cover property (@(posedge mclk) disable iff (!arst_n)
    !s_serial && !s_dual && switch_on != `SWITCH_RESET);
  c_reset_hit: cover property (@(posedge mclk) disable iff (!arst_n)
    !s_rst_n);
  c_daisy_high: cover property (@(posedge mclk) disable iff (!arst_n)
    s_serial && sel_lsb_out);
endmodule

/* logic/mux_ctl_regs.svh */
`ifndef MUX_CTL_REGS_SVH
`define MUX_CTL_REGS_SVH
`define SHIFT_BITS      4
`define SWITCH_COUNT    8
`define SHIFT_RESET     4'h0
`define SWITCH_RESET    8'h00
`define SEL_RESET       3'h0
`define DOUT_RESET      1'b0
`define SYNC_RESET      8'hC0
`define STROBE_IDLE     1'b1
`define SWITCH_ONE      8'h01
`define ODD_SWITCHES    8'hAA
`define MID_SWITCHES    8'hCC
`endif

/* logic/mux_ctl_pkg.sv */
package mux_ctl_pkg;
  typedef struct packed {
    logic       sel_msb;
    logic       sel_mid;
    logic       sel_lsb;
    logic       enable;
  } selection_s;
  typedef logic [7:0] switch_t;
endpackage

/* bench/mux_host_model.sv */
module mux_host_model
(
  input  wire logic mclk,
  output logic      strobe,
  output logic      msb,
  output logic      mid,
  output logic      lsb,
  output logic      en
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    strobe = 1'b1;
    msb = 1'b0;
    mid = 1'b0;
    lsb = 1'b0;
    en = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  // Wait n edges, then step just past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // Parallel load through the transparent latch
  task automatic par(input logic [2:0] a, input logic e);
    {msb, mid, lsb, en} = {a, e};
    strobe = 1'b0;
    tick(8);
    strobe = 1'b1;
    tick(2);
  endtask
  // Change data and enable pins only, strobe untouched
  task automatic pins(input logic d, input logic e);
    mid = d;
    en = e;
    tick(8);
  endtask
  // Serial frame, first bit first, 125 ns shift clock
  task automatic ser(input logic [3:0] w);
    strobe = 1'b0;
    for (int i = 3; i >= 0; i--)
    begin
      mid = w[i];
      tick(12);
      msb = 1'b1;
      tick(13);
      msb = 1'b0;
    end
    tick(12);
    strobe = 1'b1;
    mid = ~mid;
    tick(8);
  endtask
endmodule

/* bench/mux_switch_control_port_bench.sv */
module mux_switch_control_port_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import mux_ctl_pkg::*;
  logic    mclk, arst_n, rst_sw_n, ser_mode, dual;
  logic    strobe, msb, mid, lsb_host, en, lsb_out, lsb_oe;
  switch_t sw;
  int      errors, n_checks;
  wire logic lsb_pin = lsb_oe ? lsb_out : lsb_host;
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  mux_host_model host_i (.mclk(mclk), .strobe(strobe), .msb(msb), .mid(mid), .lsb(lsb_host), .en(en));
  mux_switch_control_port mux_switch_control_port_i (.mclk(mclk), .arst_n(arst_n), .switch_reset_n(rst_sw_n),
    .hold_strobe(strobe), .sel_msb(msb), .sel_mid(mid), .sel_lsb_in(lsb_pin), .switch_enable(en),
    .interface_select(ser_mode), .dual_config(dual), .sel_lsb_out(lsb_out), .sel_lsb_oe(lsb_oe), .switch_on(sw));
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("errors %0d checks %0d", errors, n_checks);
    if (errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    #200us;
    errors++;
    end_of_test;
  end
  ////////////////////////////////////////////////////////////
  initial
  begin
    arst_n = 1'b0;
    rst_sw_n = 1'b1;
    ser_mode = 1'b0;
    dual = 1'b0;
    errors = 0;
    n_checks = 0;
    repeat (10) @(posedge mclk);
    #1 arst_n = 1'b1;
    host_i.tick(4);
    chk(sw, 8'h00);
    chk({7'h00, lsb_oe}, 8'h00);
    for (int a = 0; a < 8; a++)
    begin
      host_i.par(3'(a), 1'b1);
      chk(sw, 8'h01 << a);
    end
    dual = 1'b1;
    host_i.par(3'h2, 1'b1);
    chk(sw, 8'h44);
    host_i.par(3'h6, 1'b1);
    chk(sw, 8'h44);
    host_i.pins(1'b0, 1'b0);
    chk(sw, 8'h44);
    host_i.par(3'h2, 1'b0);
    chk(sw, 8'h00);
    host_i.par(3'h1, 1'b1);
    chk(sw, 8'h22);
    rst_sw_n = 1'b0;
    host_i.tick(8);
    chk(sw, 8'h00);
    rst_sw_n = 1'b1;
    dual = 1'b0;
    ser_mode = 1'b1;
    host_i.tick(4);
    chk({7'h00, lsb_oe}, 8'h01);
    host_i.ser(4'h4);
    chk(sw, 8'h04);
    chk({7'h00, lsb_pin}, 8'h00);
    host_i.ser(4'hB);
    chk(sw, 8'h20);
    chk({7'h00, lsb_pin}, 8'h01);
    host_i.pins(1'b0, 1'b0);
    chk(sw, 8'h00);
    host_i.pins(1'b0, 1'b1);
    chk(sw, 8'h20);
    rst_sw_n = 1'b0;
    host_i.tick(8);
    chk(sw, 8'h00);
    chk({7'h00, lsb_pin}, 8'h00);
    end_of_test;
  end
endmodule
